/* File: hw/plm_consts.svh */
// Functional notes
// RULE1 - Link indication changes within 15 us of loss; the code takes 40 us when fast link drop is off
// RULE2 - Fast link drop uses a 10 us window
// RULE3 - One open receive conductor also drops link
// RULE4 - Valid symbols never change link state
// RULE5 - Frames pass with preamble length untouched
// RULE6 - Low-power idle supported, disabled after reset
// RULE7 - Receive error driven toward the controller
// RULE8 - Four LEDs, selectable 100FD, selectable polarity
// RULE9 - Management address from three strap pins, default 1
// RULE10 - Auto-negotiation strap, high enables it
// RULE11 - Link comes up without management access
// RULE12 - Management clock at most 24 MHz
// RULE13 - Controller in reset keeps PHY disabled
// RULE14 - Controller samples link indication every 10 us
// RULE15 - Controller delays transmit by 0-30 ns steps; the code steps in whole 25 ns cycles, 0-75 ns
// RULE16 - Same clock phase on every power-up, link
// RULE17 - Strap limits advertisement to 100 Mbit FD
// RULE18 - Software should clear energy-detect bit 0
// RULE19 - PHY address equals port number plus offset
// RULE20 - One shared reference, no transmit FIFO
// RULE21 - Report 10 and 100 full-duplex capability
// RULE22 - Automatic crossover of the receive pair
// RULE23 - Straps latched once after reset release
`ifndef PLM_CONSTS_SVH
`define PLM_CONSTS_SVH
`define PLM_CLK_NS 25
`define PLM_US_CYC(us) (((us) * 1000) / `PLM_CLK_NS)
`define PLM_FLD_WIN_US 10
`define PLM_STD_WIN_US 40
`define PLM_CHECK_US 10
`define PLM_TX_STEP_NS 10
`define PLM_MDC_MAX_MHZ 24
`define PLM_MDC_HALF 4
`define PLM_PREAMBLE 6'h20
`define PLM_HDR_LAST 6'h0C
`define PLM_DATA_LAST 6'h0F
`define PLM_TA_FIRST 6'h2E
`define PLM_RD_FIRST 6'h30
`define PLM_FRAME_LAST 6'h3F
`define PLM_REG_BASIC 5'h01
`define PLM_REG_ADV 5'h04
`define PLM_REG_EDC 5'h0B
`define PLM_REG_EXTA 5'h0D
`define PLM_REG_EXTD 5'h0E
`define PLM_REG_STS 5'h10
`define PLM_EXT_LEDMUX 16'h0025
`define PLM_EXT_LEDFN 16'h0460
`define PLM_EDC_RST 16'h0009
`define PLM_LEDMUX_RST 16'h0000
`define PLM_LEDFN_RST 16'h5555
`define PLM_EDC_ENERGY 0
`define PLM_EDC_FLD 3
`define PLM_EDC_LPI 4
`define PLM_BS_CAPS 16'h7800
`define PLM_ADV_ALL 16'h01E1
`define PLM_ADV_100FD 16'h0101
`define PLM_LED_100FD 4'h5
`define PLM_LED_LINK 4'h1
`define PLM_LED_ACT 4'h2
`define PLM_STRAP_ADDR_DFLT 3'h1
`define PLM_WB_CTRL 4'h0
`define PLM_WB_STATUS 4'h4
`define PLM_WB_CMD 4'h8
`define PLM_WB_RDATA 4'hC
`endif

/* File: hw/plm_pkg.sv */
package plm_pkg;
  typedef enum logic [1:0] {MS_HUNT, MS_HDR, MS_TA, MS_DATA} plm_mstate_t;
  typedef enum logic {MM_IDLE, MM_SHIFT} plm_master_t;
endpackage : plm_pkg

/* File: hw/plm_link_if.sv */
`timescale 1ns/1ps
interface plm_link_if;
  logic mdc;
  logic ctrlMdioOut;
  logic ctrlMdioOe;
  logic devMdioOut;
  logic devMdioOe;
  logic mdio;
  logic phyEnable;
  logic txEn;
  logic [3:0] txd;
  logic rxDv;
  logic [3:0] rxd;
  logic rxEr;
  logic [3:0] led;
  // Shared wire with a pull-up when neither end drives
  assign mdio = ctrlMdioOe ? ctrlMdioOut : (devMdioOe ? devMdioOut : 1'b1);
  modport dev (input mdc, mdio, phyEnable, txEn, txd,
               output devMdioOut, devMdioOe, rxDv, rxd, rxEr, led);
  modport ctrl (input mdio, rxDv, rxd, rxEr, led,
                output mdc, ctrlMdioOut, ctrlMdioOe, phyEnable, txEn, txd);
endinterface : plm_link_if

/* File: hw/plm_sync.sv */
`timescale 1ns/1ps
module plm_sync #(parameter int W = 1) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta;
  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule : plm_sync

/* File: hw/plm_phy_dev.sv */
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
`include "plm_consts.svh"
module plm_phy_dev import plm_pkg::*; (
  input wire logic clk,
  input wire logic resetn,
  plm_link_if.dev lnk,
  input wire logic [1:0] linePairA,
  input wire logic [1:0] linePairB,
  input wire logic lineSymOk,
  input wire logic lineFull100,
  input wire logic lineRxDv,
  input wire logic [3:0] lineRxd,
  input wire logic lineRxEr,
  input wire logic [2:0] strapAddr,
  input wire logic strapAutoNeg,
  input wire logic strapAdv100,
  output logic lineTxEn,
  output logic [3:0] lineTxd,
  output logic lineLpi
);
  localparam logic [11:0] FLD_CYC = 12'(`PLM_US_CYC(`PLM_FLD_WIN_US));
  localparam logic [11:0] STD_CYC = 12'(`PLM_US_CYC(`PLM_STD_WIN_US));

  // LED source select, shared by all four LEDs
  function automatic logic ledSrc(input logic [3:0] fn, input logic l100, input logic lup,
                                  input logic act);
    ledSrc = (fn == `PLM_LED_100FD) ? l100 : (fn == `PLM_LED_LINK) ? lup :
             (fn == `PLM_LED_ACT) ? act : 1'b0;
  endfunction : ledSrc

  logic [13:0] syncOut;
  logic [1:0] pA, pB;
  logic symOk, full100, mdcS, mdioS, enS, anS, adv100S;
  logic [2:0] addrS;
  plm_sync #(.W(14)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .din({linePairA, linePairB, lineSymOk, lineFull100, lnk.mdc, lnk.mdio, lnk.phyEnable,
          strapAddr, strapAutoNeg, strapAdv100}),
    .dout(syncOut)
  );
  assign {pA, pB, symOk, full100, mdcS, mdioS, enS, addrS, anS, adv100S} = syncOut;

  // Straps, held until the next reset
  logic [1:0] strapCnt;
  logic strapDone;
  logic [2:0] phyAddr;
  logic autoNeg, adv100Only;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strapCnt <= 2'h0;
      strapDone <= 1'b0;
      phyAddr <= `PLM_STRAP_ADDR_DFLT; // [RULE9]
      autoNeg <= 1'b1;
      adv100Only <= 1'b0;
    end else if (!strapDone) begin
      strapCnt <= strapCnt + 2'h1;
      if (strapCnt == 2'h2) begin
        // Wait for the synchroniser to settle before catching the straps
        strapDone <= 1'b1; // [RULE23]
        phyAddr <= addrS; // [RULE9]
        autoNeg <= anS; // [RULE10]
        adv100Only <= adv100S; // [RULE17]
      end
    end
  end

  // Register file
  logic [15:0] edc, ledMux, ledFn, extAddr;
  logic linkUp, swap;
  wire link100 = linkUp & full100; // [RULE8]
  wire [15:0] basicWord = `PLM_BS_CAPS | {10'h000, linkUp & autoNeg, 1'b0, autoNeg, linkUp,
                          2'b01}; // [RULE21] [RULE10]
  wire [15:0] advWord = adv100Only ? `PLM_ADV_100FD : `PLM_ADV_ALL; // [RULE17]
  wire [15:0] extWord = (extAddr == `PLM_EXT_LEDMUX) ? ledMux :
                        (extAddr == `PLM_EXT_LEDFN) ? ledFn : 16'h0000;
  wire [15:0] stsWord = {13'h0000, lineLpi, swap, linkUp};

  // Management slave: preamble hunt, header, turnaround, data
  plm_mstate_t mState;
  logic [5:0] mCnt;
  logic [15:0] sh;
  logic isRead, hit, mdcQ;
  logic [4:0] regAd;
  wire mdcRise = mdcS & ~mdcQ; // [RULE12]
  wire [12:0] hdr = {sh[11:0], mdioS};
  wire [15:0] wrWord = {sh[14:0], mdioS};
  wire [4:0] hdrReg = hdr[4:0];
  wire [15:0] rdWord = (hdrReg == `PLM_REG_BASIC) ? basicWord :
                       (hdrReg == `PLM_REG_ADV) ? advWord :
                       (hdrReg == `PLM_REG_EDC) ? edc :
                       (hdrReg == `PLM_REG_EXTA) ? extAddr :
                       (hdrReg == `PLM_REG_EXTD) ? extWord :
                       (hdrReg == `PLM_REG_STS) ? stsWord : 16'h0000;
  wire wrDone = mdcRise & (mState == MS_DATA) & (mCnt == `PLM_DATA_LAST) & ~isRead & hit;

  // Frame sequencing follows synchronised MDC edges, so any rate works
  // while a half period spans at least three clk cycles
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mState <= MS_HUNT;
      mCnt <= 6'h00;
      sh <= 16'h0000;
      isRead <= 1'b0;
      hit <= 1'b0;
      regAd <= 5'h00;
      mdcQ <= 1'b0;
      lnk.devMdioOut <= 1'b1;
      lnk.devMdioOe <= 1'b0;
    end else begin
      mdcQ <= mdcS;
      if (mdcRise) begin
        case (mState)
          MS_HUNT: begin
            if (mdioS) begin
              mCnt <= (mCnt == `PLM_PREAMBLE) ? mCnt : mCnt + 6'h01;
            end else begin
              mCnt <= 6'h00;
              if (mCnt == `PLM_PREAMBLE) begin
                mState <= MS_HDR;
              end
            end
          end
          MS_HDR: begin
            sh <= {sh[14:0], mdioS};
            mCnt <= mCnt + 6'h01;
            if (mCnt == `PLM_HDR_LAST) begin
              mState <= MS_TA;
              mCnt <= 6'h00;
              isRead <= (hdr[11:10] == 2'b10);
              hit <= (hdr[9:5] == {2'b00, phyAddr}); // [RULE9]
              regAd <= hdrReg;
              sh <= rdWord;
            end
          end
          MS_TA: begin
            mCnt <= mCnt + 6'h01;
            if (isRead & hit) begin
              lnk.devMdioOe <= 1'b1;
              lnk.devMdioOut <= (mCnt == 6'h00) ? 1'b0 : sh[15];
            end
            if (mCnt != 6'h00) begin
              mState <= MS_DATA;
              mCnt <= 6'h00;
              if (isRead) begin
                sh <= {sh[14:0], 1'b0};
              end
            end
          end
          MS_DATA: begin
            mCnt <= mCnt + 6'h01;
            sh <= isRead ? {sh[14:0], 1'b0} : wrWord;
            lnk.devMdioOut <= sh[15];
            if (mCnt == `PLM_DATA_LAST) begin
              mState <= MS_HUNT;
              mCnt <= 6'h00;
              lnk.devMdioOe <= 1'b0;
              lnk.devMdioOut <= 1'b1;
            end
          end
          default: mState <= MS_HUNT;
        endcase
      end
    end
  end

  // Register writes; defaults alone bring the link up
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      edc <= `PLM_EDC_RST; // [RULE11] [RULE6]
      ledMux <= `PLM_LEDMUX_RST;
      ledFn <= `PLM_LEDFN_RST; // [RULE11]
      extAddr <= 16'h0000;
    end else if (wrDone) begin
      case (regAd)
        `PLM_REG_EDC: edc <= wrWord;
        `PLM_REG_EXTA: extAddr <= wrWord;
        `PLM_REG_EXTD: begin
          if (extAddr == `PLM_EXT_LEDMUX) begin
            ledMux <= wrWord;
          end
          if (extAddr == `PLM_EXT_LEDFN) begin
            ledFn <= wrWord;
          end
        end
        default: edc <= edc;
      endcase
    end
  end

  // Link supervision: both conductors must carry energy
  wire [1:0] rxPair = swap ? pB : pA; // [RULE22]
  wire energy = &rxPair; // [RULE3]
  // Symbol content matters only when energy detect treats bad codes as loss
  wire lossCond = ~energy | (edc[`PLM_EDC_ENERGY] & ~symOk); // [RULE4]
  wire [11:0] win = edc[`PLM_EDC_FLD] ? FLD_CYC : STD_CYC; // [RULE2] [RULE1]
  logic [11:0] winCnt;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      linkUp <= 1'b0;
      swap <= 1'b0;
      winCnt <= 12'h000;
    end else if (!enS) begin
      linkUp <= 1'b0; // [RULE13]
      winCnt <= 12'h000;
    end else if (linkUp) begin
      winCnt <= lossCond ? winCnt + 12'h001 : 12'h000;
      if (lossCond && winCnt >= win - 12'h001) begin
        linkUp <= 1'b0; // [RULE1] [RULE2]
        winCnt <= 12'h000;
      end
    end else begin
      winCnt <= lossCond ? 12'h000 : winCnt + 12'h001;
      if (!lossCond && winCnt >= win - 12'h001) begin
        linkUp <= 1'b1; // [RULE11]
      end
      // Energy only on the other pair means the cable is crossed
      if (!energy && (swap ? &pA : &pB)) begin
        swap <= ~swap; // [RULE22]
      end
    end
  end

  // Media data path: fixed one-cycle latency in each direction on the
  // shared reference, so phase is the same after every power-up and link
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lnk.rxDv <= 1'b0;
      lnk.rxd <= 4'h0;
      lnk.rxEr <= 1'b0;
      lineTxEn <= 1'b0;
      lineTxd <= 4'h0;
      lineLpi <= 1'b0;
    end else begin
      lnk.rxDv <= lineRxDv & linkUp; // [RULE5] [RULE16] [RULE20]
      lnk.rxd <= lineRxd;
      lnk.rxEr <= lineRxEr & linkUp; // [RULE7]
      lineTxEn <= lnk.txEn & linkUp; // [RULE5]
      lineTxd <= lnk.txd;
      lineLpi <= edc[`PLM_EDC_LPI] & linkUp & ~lineRxDv & ~lnk.txEn; // [RULE6]
    end
  end

  // LED drivers, polarity bit set means active high
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_led
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          lnk.led[i] <= 1'b1;
        end else begin
          lnk.led[i] <= ledSrc(ledFn[4*i+3:4*i], link100, linkUp, lineRxDv) ^
                        ~ledMux[i]; // [RULE8]
        end
      end
    end
  endgenerate
endmodule : plm_phy_dev

/* File: hw/plm_slave_ctrl.sv */
`timescale 1ns/1ps
`include "plm_consts.svh"
module plm_slave_ctrl import plm_pkg::*; (
  input wire logic clk,
  input wire logic resetn,
  plm_link_if.ctrl lnk,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [3:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  output logic wbAck,
  input wire logic userTxEn,
  input wire logic [3:0] userTxd,
  output logic userRxDv,
  output logic [3:0] userRxd,
  output logic userRxEr
);
  localparam logic [9:0] CHECK_CYC = 10'(`PLM_US_CYC(`PLM_CHECK_US));
  // Half period of four cycles gives 5 MHz, well under the 24 MHz limit
  localparam logic [2:0] MDC_HALF = 3'(`PLM_MDC_HALF);
  // One shift step in whole cycles, rounded up
  localparam int STEP_CYC = (`PLM_TX_STEP_NS + `PLM_CLK_NS - 1) / `PLM_CLK_NS;

  logic [1:0] syncOut;
  logic mdioS, ledS;
  plm_sync #(.W(2)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .din({lnk.mdio, lnk.led[0]}),
    .dout(syncOut)
  );
  assign {mdioS, ledS} = syncOut;

  // Bus decode
  logic [3:0] ctrl;
  logic linkSeen, busy;
  logic [15:0] rdData;
  wire wbReq = wbCyc & wbStb & ~wbAck;
  wire wrCtrl = wbReq & wbWe & (wbAdr == `PLM_WB_CTRL) & wbSel[0];
  wire wrCmd = wbReq & wbWe & (wbAdr == `PLM_WB_CMD) & (&wbSel) & ~busy;
  wire [31:0] rdMux = (wbAdr == `PLM_WB_CTRL) ? {28'h0000000, ctrl} :
                      (wbAdr == `PLM_WB_STATUS) ? {30'h00000000, busy, linkSeen} :
                      (wbAdr == `PLM_WB_RDATA) ? {16'h0000, rdData} : 32'h00000000;

  // One wait state on every access; unmapped reads return zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wbAck <= 1'b0;
      wbDatO <= 32'h00000000;
      ctrl <= 4'h0;
    end else begin
      wbAck <= wbReq;
      wbDatO <= rdMux;
      if (wrCtrl) begin
        ctrl <= wbDatI[3:0];
      end
    end
  end

  // PHY stays disabled until software enables it after reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lnk.phyEnable <= 1'b0; // [RULE13]
    end else begin
      lnk.phyEnable <= ctrl[0];
    end
  end

  // Periodic link check on the first LED, polarity from ctrl[3]
  logic [9:0] chkCnt;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      chkCnt <= 10'h000;
      linkSeen <= 1'b0;
    end else begin
      chkCnt <= (chkCnt == CHECK_CYC - 10'h001) ? 10'h000 : chkCnt + 10'h001;
      if (chkCnt == CHECK_CYC - 10'h001) begin
        linkSeen <= ledS ^ ~ctrl[3]; // [RULE14]
      end
    end
  end

  // Transmit shift line; each step is rounded up to whole cycles,
  // the cost of running from the shared reference instead of a fast clock
  localparam int TAPS = 3 * STEP_CYC;
  logic [4:0] txLine [0:TAPS];
  assign txLine[0] = {userTxEn, userTxd};
  genvar t;
  generate
    for (t = 1; t <= TAPS; t++) begin : g_tx
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          txLine[t] <= 5'h00;
        end else begin
          txLine[t] <= txLine[t-1];
        end
      end
    end
  endgenerate
  wire [4:0] txSel = txLine[32'(ctrl[2:1]) * STEP_CYC]; // [RULE15]

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {lnk.txEn, lnk.txd} <= 5'h00;
      userRxDv <= 1'b0;
      userRxd <= 4'h0;
      userRxEr <= 1'b0;
    end else begin
      {lnk.txEn, lnk.txd} <= txSel; // [RULE15] [RULE20]
      userRxDv <= lnk.rxDv;
      userRxd <= lnk.rxd;
      userRxEr <= lnk.rxEr;
    end
  end

  // Management master; the address field is software's port number plus
  // offset, and clearing energy-detect bit 0 is a write software issues
  plm_master_t mState;
  logic [2:0] divCnt;
  logic [5:0] bitIdx;
  logic [63:0] frame;
  logic isRead;
  wire divWrap = (divCnt == MDC_HALF - 3'h1);
  wire mdcFall = (mState == MM_SHIFT) & divWrap & lnk.mdc;
  wire mdcRise = (mState == MM_SHIFT) & divWrap & ~lnk.mdc;
  wire [1:0] cmdOp = wbDatI[26] ? 2'b01 : 2'b10;
  wire [1:0] cmdTa = wbDatI[26] ? 2'b10 : 2'b11;
  assign busy = (mState == MM_SHIFT);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mState <= MM_IDLE;
      divCnt <= 3'h0;
      bitIdx <= 6'h00;
      frame <= 64'h0000000000000000;
      isRead <= 1'b0;
      rdData <= 16'h0000;
      lnk.mdc <= 1'b0;
      lnk.ctrlMdioOut <= 1'b1;
      lnk.ctrlMdioOe <= 1'b0;
    end else begin
      case (mState)
        MM_IDLE: begin
          divCnt <= 3'h0;
          if (wrCmd) begin
            mState <= MM_SHIFT;
            bitIdx <= 6'h00;
            isRead <= ~wbDatI[26];
            frame <= {32'hFFFFFFFF, 2'b01, cmdOp, wbDatI[25:16], cmdTa,
                      wbDatI[15:0]}; // [RULE19] [RULE18]
            lnk.ctrlMdioOe <= 1'b1;
            lnk.ctrlMdioOut <= 1'b1;
          end
        end
        MM_SHIFT: begin
          divCnt <= divWrap ? 3'h0 : divCnt + 3'h1;
          if (divWrap) begin
            lnk.mdc <= ~lnk.mdc; // [RULE12]
          end
          if (mdcRise && isRead && bitIdx >= `PLM_RD_FIRST) begin
            rdData <= {rdData[14:0], mdioS};
          end
          if (mdcFall) begin
            bitIdx <= bitIdx + 6'h01;
            frame <= {frame[62:0], 1'b1};
            lnk.ctrlMdioOut <= frame[62];
            if (isRead && bitIdx + 6'h01 >= `PLM_TA_FIRST) begin
              lnk.ctrlMdioOe <= 1'b0;
            end
            if (bitIdx == `PLM_FRAME_LAST) begin
              mState <= MM_IDLE;
              lnk.ctrlMdioOe <= 1'b0;
              lnk.ctrlMdioOut <= 1'b1;
            end
          end
        end
        default: mState <= MM_IDLE;
      endcase
    end
  end
endmodule : plm_slave_ctrl

/* File: sim/plm_link_chk.sv */
`timescale 1ns/1ps
module plm_link_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic mdc,
  input wire logic ctrlMdioOe,
  input wire logic devMdioOe,
  input wire logic phyEnable,
  input wire logic [3:0] led
);
  // One clock domain, so clocking and reset are given once
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  chk_mdio_single:
    assert property (!(ctrlMdioOe && devMdioOe))
      else $error("both ends drive the management data line");
  chk_mdc_high_time:
    assert property ($rose(mdc) |-> mdc [*4] ##1 !mdc)
      else $error("management clock high phase not four cycles");
  chk_mdc_low_time:
    assert property ($fell(mdc) |-> !mdc [*4])
      else $error("management clock low phase too short");
  chk_frame_start_low:
    assert property ($rose(ctrlMdioOe) |-> !mdc)
      else $error("frame started with management clock high");
  chk_turnaround_gap:
    assert property ($fell(ctrlMdioOe) |-> !devMdioOe [*4])
      else $error("device drove data line inside turnaround");
  chk_led_dark_off:
    assert property (!phyEnable [*8] |=> led == 4'hF)
      else $error("link shown while the device is disabled");
  chk_no_early_link:
    assert property ($rose(phyEnable) |-> (led == 4'hF) [*8])
      else $error("link shown right after enable");
  chk_led_unison:
    assert property (led == 4'h0 || led == 4'hF)
      else $error("default leds disagree about the link");
  chk_link_needs_en:
    assert property ($fell(led[0]) |-> $past(phyEnable, 3))
      else $error("link came up without enable");
endmodule : plm_link_chk

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`include "plm_consts.svh"
module tb_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] linePairA = 2'h0;
  logic [1:0] linePairB = 2'h0;
  logic lineSymOk = 1'b1;
  logic lineFull100 = 1'b1;
  logic lineRxDv = 1'b0;
  logic [3:0] lineRxd = 4'h0;
  logic lineRxEr = 1'b0;
  logic [2:0] strapAddr = 3'h1;
  logic strapAutoNeg = 1'b1;
  logic strapAdv100 = 1'b1;
  logic lineTxEn;
  logic [3:0] lineTxd;
  logic lineLpi;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [3:0] wbAdr = 4'h0;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatI = 32'h0;
  logic [31:0] wbDatO;
  logic wbAck;
  logic userTxEn = 1'b0;
  logic [3:0] userTxd = 4'h0;
  logic userRxDv;
  logic [3:0] userRxd;
  logic userRxEr;
  int error_cnt = 0;
  int tests_run = 0;

  // 40 MHz system clock
  always #12.5 clk = ~clk;

  plm_link_if lnk();
  plm_phy_dev plm_phy_dev_i (.clk(clk), .resetn(resetn), .lnk(lnk), .linePairA(linePairA),
    .linePairB(linePairB), .lineSymOk(lineSymOk), .lineFull100(lineFull100),
    .lineRxDv(lineRxDv), .lineRxd(lineRxd), .lineRxEr(lineRxEr), .strapAddr(strapAddr),
    .strapAutoNeg(strapAutoNeg), .strapAdv100(strapAdv100), .lineTxEn(lineTxEn),
    .lineTxd(lineTxd), .lineLpi(lineLpi));
  plm_slave_ctrl plm_slave_ctrl_i (.clk(clk), .resetn(resetn), .lnk(lnk), .wbCyc(wbCyc),
    .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI),
    .wbDatO(wbDatO), .wbAck(wbAck), .userTxEn(userTxEn), .userTxd(userTxd),
    .userRxDv(userRxDv), .userRxd(userRxd), .userRxEr(userRxEr));
  plm_link_chk plm_link_chk_i (.clk(clk), .resetn(resetn), .mdc(lnk.mdc),
    .ctrlMdioOe(lnk.ctrlMdioOe), .devMdioOe(lnk.devMdioOe), .phyEnable(lnk.phyEnable),
    .led(lnk.led));

  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // A wait that ran out ends the run at once
  task automatic hang(input string what);
    error_cnt++;
    $display("mismatch %s expected done seen timeout", what);
    stop_test();
  endtask : hang

  // Classic single cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat,
                    output logic [31:0] rd);
    int k;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= 4'hF;
    wbDatI <= dat;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (wbAck === 1'b1) break;
    end
    if (k == 50) hang("wbAck");
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask : wb

  // One management frame, polled until the controller is idle again
  task automatic mgmt(input logic we, input logic [4:0] phy, input logic [4:0] rg,
                      input logic [15:0] d, output logic [15:0] rd);
    logic [31:0] v;
    int k;
    wb(1'b1, `PLM_WB_CMD, {5'h00, we, phy, rg, d}, v);
    for (k = 0; k < 2000; k++) begin
      wb(1'b0, `PLM_WB_STATUS, 32'h0, v);
      if (v[1] === 1'b0) break;
    end
    if (k == 2000) hang("busy");
    wb(1'b0, `PLM_WB_RDATA, 32'h0, v);
    rd = v[15:0];
  endtask : mgmt

  task automatic wait_led(input logic [3:0] exp, input int lim, output int n);
    for (n = 0; n < lim; n++) begin
      @(posedge clk);
      if (lnk.led === exp) break;
    end
    if (n == lim) hang("led");
  endtask : wait_led

  // Power-on defaults, straps and a frame to a foreign address
  task automatic t_config;
    logic [15:0] r;
    mgmt(1'b0, 5'h01, `PLM_REG_BASIC, 16'h0, r);
    check("capabilities", `PLM_BS_CAPS, r & `PLM_BS_CAPS);
    mgmt(1'b0, 5'h01, `PLM_REG_EDC, 16'h0, r);
    check("energy control", `PLM_EDC_RST, r);
    mgmt(1'b0, 5'h01, `PLM_REG_ADV, 16'h0, r);
    check("advertisement", `PLM_ADV_100FD, r);
    mgmt(1'b0, 5'h02, `PLM_REG_EDC, 16'h0, r);
    check("foreign address", 16'hFFFF, r);
    strapAddr <= 3'h5;
    mgmt(1'b0, 5'h01, `PLM_REG_EDC, 16'h0, r);
    check("latched address", `PLM_EDC_RST, r);
    check("low power idle", 1'b0, lineLpi);
  endtask : t_config

  // Receive frame: length, preamble, error flag, link steady on valid data
  task automatic t_data;
    int i;
    int dv;
    int pre;
    int er;
    int bad;
    dv = 0;
    pre = 0;
    er = 0;
    bad = 0;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      lineRxDv <= (i < 24);
      lineRxd <= (i < 15) ? 4'h5 : ((i == 15) ? 4'hD : {i[1:0], 2'b10});
      lineRxEr <= (i == 20);
      if (userRxDv === 1'b1) dv++;
      if (userRxDv === 1'b1 && userRxd === 4'h5) pre++;
      if (userRxEr === 1'b1) er++;
      if (lnk.led !== 4'h0) bad++;
    end
    check("rx length", 24, dv);
    check("rx preamble", 15, pre);
    check("rx error", 1, er);
    check("led steady", 0, bad);
  endtask : t_data

  // Every transmit shift setting, latency grows one cycle a step
  task automatic t_shift;
    int s;
    int i;
    int lat;
    int cnt;
    logic [31:0] v;
    for (s = 0; s < 4; s++) begin
      wb(1'b1, `PLM_WB_CTRL, {28'h0, 1'b0, s[1:0], 1'b1}, v);
      lat = -1;
      cnt = 0;
      @(posedge clk);
      userTxEn <= 1'b1;
      userTxd <= 4'h5;
      for (i = 0; i < 28; i++) begin
        @(posedge clk);
        if (i == 11) userTxEn <= 1'b0;
        if (lineTxEn === 1'b1 && cnt == 0) lat = i;
        if (lineTxEn === 1'b1 && lineTxd === 4'h5) cnt++;
      end
      // One register stage in each end, then one cycle per step
      check("tx shift", 2 + s, lat);
      check("tx length", 12, cnt);
    end
    wb(1'b1, `PLM_WB_CTRL, 32'h1, v);
  endtask : t_shift

  initial begin
    int n;
    logic [31:0] v;
    logic [15:0] r;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    t_config();
    wb(1'b1, `PLM_WB_CTRL, 32'h1, v);
    linePairA <= 2'h3;
    wait_led(4'h0, 3000, n);
    check("led on", 4'h0, lnk.led);
    repeat (450) @(posedge clk);
    wb(1'b0, `PLM_WB_STATUS, 32'h0, v);
    check("link sampled", 1'b1, v[0]);
    // Active-high reading of an active-low LED must report no link
    wb(1'b1, `PLM_WB_CTRL, 32'h9, v);
    repeat (450) @(posedge clk);
    wb(1'b0, `PLM_WB_STATUS, 32'h0, v);
    check("first_led_pin polarity", 1'b0, v[0]);
    // LED polarity flipped through the indirect mux register and back
    mgmt(1'b1, 5'h01, `PLM_REG_EXTA, `PLM_EXT_LEDMUX, r);
    mgmt(1'b1, 5'h01, `PLM_REG_EXTD, 16'h000F, r);
    wait_led(4'hF, 20, n);
    check("led active high", 4'hF, lnk.led);
    mgmt(1'b1, 5'h01, `PLM_REG_EXTD, 16'h0000, r);
    wait_led(4'h0, 20, n);
    check("led active low", 4'h0, lnk.led);
    t_data();
    t_shift();
    // One conductor lost, fast drop active by default
    linePairA <= 2'h2;
    wait_led(4'hF, 3000, n);
    check("fast drop", 1'b1, n >= 400 && n < 600);
    linePairA <= 2'h0;
    linePairB <= 2'h3;
    wait_led(4'h0, 8000, n);
    check("crossover", 4'h0, lnk.led);
    mgmt(1'b1, 5'h01, `PLM_REG_EDC, 16'h0001, r);
    linePairB <= 2'h1;
    wait_led(4'hF, 3000, n);
    check("slow drop", 1'b1, n > 600);
    linePairB <= 2'h3;
    wait_led(4'h0, 8000, n);
    wb(1'b1, `PLM_WB_CTRL, 32'h0, v);
    wait_led(4'hF, 20, n);
    check("disabled", 4'hF, lnk.led);
    stop_test();
  end
endmodule : tb_top
